//--- pmt_top.sv
// module: period match timer with APB register slave and interrupt
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pmt_top
    import pmt_pkg::*;
(
    input  wire logic        clk_i,      // 10 MHz system clock
    input  wire logic        rst_i,      // sync reset, active high
    input  wire logic        psel_i,     // apb select
    input  wire logic        penable_i,  // apb enable
    input  wire logic        pwrite_i,   // apb write
    input  wire logic [11:0] paddr_i,    // apb byte address
    input  wire logic [31:0] pwdata_i,   // apb write data
    output logic      [31:0] prdata_o,   // apb read data
    output logic             pready_o,   // apb ready
    output logic             pslverr_o,  // apb error
    output logic             irq_o,      // level interrupt
    output logic             pwm_period_o // pulse at period end
);
    typedef struct packed {
        logic [7:0]  count;
        logic [7:0]  period;
        logic [6:0]  ctrl;
        logic        flag;
        logic        mask;
        logic [1:0]  div4;
        logic        tick;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        irq;
        logic        pwm;
    } pmt_top_s;

    pmt_top_s st_reg;
    pmt_top_s st_next;

    pmt_scale_if pre_if ();
    pmt_scale_if post_if ();

    logic        setup;
    logic        wr_acc;
    logic        wr_count;
    logic        wr_ctrl;
    logic        match;
    logic        inc_ev;
    logic        on;
    logic [1:0]  ps_sel;
    logic        mapped;
    logic [31:0] rd_val;

    assign setup    = psel_i && !penable_i;
    assign wr_acc   = psel_i && penable_i && pwrite_i && st_reg.ready;
    assign wr_count = wr_acc && paddr_i == PMT_COUNT_OFS;
    assign wr_ctrl  = wr_acc && paddr_i == PMT_CTRL_OFS;
    assign on       = st_reg.ctrl[PMT_ON_BIT];
    assign ps_sel   = st_reg.ctrl[PMT_PS_LO +: 2];
    assign match    = st_reg.count == st_reg.period;

    // instruction clock: one enable every four system cycles
    always_comb begin
        pre_if.clear   = wr_count || wr_ctrl;
        pre_if.tick_in = st_reg.tick && on;
        case (ps_sel)
            PMT_PS_DIV1: pre_if.limit = 4'h0;
            PMT_PS_DIV4: pre_if.limit = PMT_PRE_MAX4;
            default:     pre_if.limit = PMT_PRE_MAX16;
        endcase
    end
    assign inc_ev = pre_if.tick_out;

    always_comb begin
        post_if.clear   = wr_count || wr_ctrl;
        post_if.tick_in = inc_ev && match;
        post_if.limit   = st_reg.ctrl[PMT_POST_LO +: 4];
    end

    pmt_scaler u_pre (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sif   (pre_if)
    );
    pmt_scaler u_post (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sif   (post_if)
    );

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr_i)
            PMT_COUNT_OFS:  rd_val[7:0] = st_reg.count;
            PMT_PERIOD_OFS: rd_val[7:0] = st_reg.period;
            PMT_CTRL_OFS:   rd_val[PMT_CTRL_W-1:0] = st_reg.ctrl;
            PMT_FLAG_OFS:   rd_val[0] = st_reg.flag;
            PMT_MASK_OFS:   rd_val[0] = st_reg.mask;
            default:        mapped = 1'b0;
        endcase
    end

    always_comb begin
        st_next      = st_reg;
        st_next.div4 = st_reg.div4 + 2'h1;
        st_next.tick = st_reg.div4 == PMT_DIV4_MAX;
        st_next.pwm  = 1'b0;
        // counter: match reload beats increment
        if (inc_ev) begin
            if (match) begin
                st_next.count = 8'h00;
                st_next.pwm   = 1'b1;
            end else begin
                st_next.count = st_reg.count + 8'h01;
            end
        end
        // apb access: one wait state, answer in second access cycle
        st_next.ready = 1'b0;
        st_next.err   = 1'b0;
        if (setup) begin
            st_next.ready = 1'b0;
        end else if (psel_i && penable_i && !st_reg.ready) begin
            st_next.ready = 1'b1;
            st_next.err   = !mapped;
            st_next.rdata = pwrite_i ? 32'h0000_0000 : rd_val;
        end
        if (wr_acc) begin
            case (paddr_i)
                PMT_COUNT_OFS:  st_next.count = pwdata_i[7:0];
                PMT_PERIOD_OFS: st_next.period = pwdata_i[7:0];
                PMT_CTRL_OFS:   st_next.ctrl =
                                    pwdata_i[PMT_CTRL_W-1:0];
                PMT_FLAG_OFS:   if (pwdata_i[0]) st_next.flag = 1'b0;
                PMT_MASK_OFS:   st_next.mask = pwdata_i[0];
                default:        st_next.mask = st_reg.mask;
            endcase
        end
        // set wins over software clear
        if (post_if.tick_out) begin
            st_next.flag = 1'b1;
        end
        st_next.irq = st_next.flag && st_next.mask;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg        <= '0;
            st_reg.count  <= PMT_COUNT_RST;
            st_reg.period <= PMT_PERIOD_RST;
            st_reg.ctrl   <= PMT_CTRL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata_o     = st_reg.rdata;
    assign pready_o     = st_reg.ready;
    assign pslverr_o    = st_reg.err;
    assign irq_o        = st_reg.irq;
    assign pwm_period_o = st_reg.pwm;

    a_count_wrap : assert property (@(posedge clk_i) disable iff (rst_i)
        inc_ev && match && !wr_count |=> st_reg.count == 8'h00)
        else $error("counter did not wrap at match");
    a_count_step : assert property (@(posedge clk_i) disable iff (rst_i)
        inc_ev && !match && !wr_count
        |=> st_reg.count == $past(st_reg.count) + 8'h01)
        else $error("counter did not step");
    a_off_hold : assert property (@(posedge clk_i) disable iff (rst_i)
        !on && !wr_acc |=> $stable(st_reg.count))
        else $error("counter moved while off");
    a_ctrl_keep : assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl && !inc_ev |=> $stable(st_reg.count))
        else $error("control write changed counter");
    a_flag_set : assert property (@(posedge clk_i) disable iff (rst_i)
        post_if.tick_out |=> st_reg.flag)
        else $error("flag not set by postscaler");
    a_rst_vals : assert property (@(posedge clk_i)
        rst_i |=> st_reg.count == PMT_COUNT_RST
                  && st_reg.period == PMT_PERIOD_RST)
        else $error("reset values wrong");
    a_tick_rate : assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.tick |=> !st_reg.tick [*3])
        else $error("instruction tick too frequent");
    a_post_gate : assert property (@(posedge clk_i) disable iff (rst_i)
        post_if.tick_in |-> match && inc_ev)
        else $error("postscaler advanced without match");
    a_pwm_end : assert property (@(posedge clk_i) disable iff (rst_i)
        pwm_period_o |-> st_reg.count == 8'h00)
        else $error("pwm period end without wrap");
    a_clr_scal : assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_count || wr_ctrl) |-> !post_if.tick_out)
        else $error("scaler fired during clearing write");
    a_pre_sel : assert property (@(posedge clk_i) disable iff (rst_i)
        ps_sel == PMT_PS_DIV1 |-> pre_if.limit == 4'h0)
        else $error("prescale one not selected");
    a_irq_lvl : assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.flag && st_reg.mask |-> irq_o)
        else $error("interrupt not raised");

    c_wrap : cover property (@(posedge clk_i) inc_ev && match);
    c_flag : cover property (@(posedge clk_i) post_if.tick_out);
    c_clr_race : cover property (@(posedge clk_i)
        post_if.tick_out && wr_acc && paddr_i == PMT_FLAG_OFS);
    c_err : cover property (@(posedge clk_i) pslverr_o);
endmodule : pmt_top
`default_nettype wire

//--- pmt_pkg.sv
// package: register map, fields and reset values of the period match timer
// Contract
// - 8-bit counter and 8-bit period registers
// - timer clocked by instruction clock, osc/4
// - prescaler 1, 4, 16 increments counter
// - counter counts up from zero to period
// - at match next increment loads zero
// - each match advances postscaler, ratios 1..16
// - postscaler output sets timer match flag
// - counter and period rw; reset 00h, FFh
// - counts only while timer-on bit set
// - ratios taken from control register fields
// - count/control write or reset clears scalers
// - control write leaves counter unchanged
// - PWM period ends at each match
package pmt_pkg;
    localparam logic [11:0] PMT_COUNT_OFS  = 12'h000;
    localparam logic [11:0] PMT_PERIOD_OFS = 12'h004;
    localparam logic [11:0] PMT_CTRL_OFS   = 12'h008;
    localparam logic [11:0] PMT_FLAG_OFS   = 12'h00C;
    localparam logic [11:0] PMT_MASK_OFS   = 12'h010;
    localparam logic [7:0]  PMT_COUNT_RST  = 8'h00;
    localparam logic [7:0]  PMT_PERIOD_RST = 8'hFF;
    localparam logic [6:0]  PMT_CTRL_RST   = 7'h00;
    // control fields
    localparam int PMT_ON_BIT   = 2;
    localparam int PMT_PS_LO    = 0;
    localparam int PMT_POST_LO  = 3;
    localparam int PMT_CTRL_W   = 7;
    // prescale encodings
    localparam logic [1:0] PMT_PS_DIV1 = 2'h0;
    localparam logic [1:0] PMT_PS_DIV4 = 2'h1;
    localparam logic [3:0] PMT_PRE_MAX4  = 4'h3;
    localparam logic [3:0] PMT_PRE_MAX16 = 4'hF;
    localparam logic [1:0] PMT_DIV4_MAX  = 2'h3;
endpackage : pmt_pkg

//--- pmt_scale_if.sv
// interface: shared clear and tick signals between timer stages
`timescale 1ns/10ps
`default_nettype none
interface pmt_scale_if;
    logic       clear;
    logic       tick_in;
    logic [3:0] limit;
    logic       tick_out;
    modport ctrl (output clear, output tick_in, output limit,
                  input tick_out);
    modport scal (input clear, input tick_in, input limit,
                  output tick_out);
endinterface : pmt_scale_if
`default_nettype wire

//--- pmt_scaler.sv
// module: divide-by-(limit+1) tick scaler with synchronous clear
`timescale 1ns/10ps
`default_nettype none
module pmt_scaler
    import pmt_pkg::*;
(
    input  wire logic   clk_i,     // system clock
    input  wire logic   rst_i,     // sync reset
    pmt_scale_if.scal   sif        // tick and clear
);
    typedef struct packed {
        logic [3:0] cnt;
    } pmt_scal_s;
    pmt_scal_s st_reg;
    pmt_scal_s st_next;
    logic      hit;

    assign hit = sif.tick_in && (st_reg.cnt == sif.limit);
    assign sif.tick_out = hit && !sif.clear;

    always_comb begin
        st_next = st_reg;
        if (sif.clear) begin
            st_next.cnt = 4'h0;
        end else if (hit) begin
            st_next.cnt = 4'h0;
        end else if (sif.tick_in) begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    a_scal_bound : assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.cnt <= sif.limit || $past(sif.limit) != sif.limit)
        else $error("scaler count beyond limit");
endmodule : pmt_scaler
`default_nettype wire

//--- tb_top.sv
// testbench: random and corner checks of the period match timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pmt_pkg::*;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        pwm;
    logic [31:0] q;
    logic        err;
    logic [7:0]  per;
    logic [7:0]  v;
    logic [3:0]  post_tab [4];
    int          errors     = 0;
    int          num_checks = 0;
    int          seed       = 23;
    int          cyc        = 0;
    int          t;
    int          n;

    pmt_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq), .pwm_period_o(pwm)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk

    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        // look at settled outputs mid-cycle, act at the next rising edge
        do begin
            @(negedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            $display("mismatch pready expected 1 seen %b", pready);
            errors++;
            summarize();
        end
        q   = prdata;
        err = pslverr;
        @(posedge clk_i);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wait_pwm();
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (pwm !== 1'b1 && t < 5000);
    endtask : wait_pwm

    function automatic int pdiv(input logic [1:0] s);
        return (s == 2'h0) ? 1 : ((s == 2'h1) ? 4 : 16);
    endfunction : pdiv

    function automatic logic [31:0] ctrl(input logic on, input logic [1:0] ps,
                                         input logic [3:0] po);
        return {25'h0, po, on, ps};
    endfunction : ctrl

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(PMT_COUNT_OFS);
        chk("count_reset", 32'h0, q);
        rd(PMT_PERIOD_OFS);
        chk("period_reset", 32'hFF, q);
        rd(PMT_CTRL_OFS);
        chk("ctrl_reset", 32'h0, q);
        rd(12'h0FC);
        chk("unmapped_err", 32'h1, {31'h0, err});
        v = 8'($random(seed));
        wr(PMT_COUNT_OFS, {24'hFF_FFFF, v});
        rd(PMT_COUNT_OFS);
        chk("count_rw", {24'h0, v}, q);
        // stopped timer keeps its count across a control write
        wr(PMT_CTRL_OFS, ctrl(1'b0, 2'h1, 4'h5));
        rd(PMT_COUNT_OFS);
        chk("count_after_ctrl", {24'h0, v}, q);
        repeat (40) @(posedge clk_i);
        rd(PMT_COUNT_OFS);
        chk("count_stopped", {24'h0, v}, q);
        for (int s = 0; s < 4; s++) begin
            per = 8'h03 + 8'($random(seed) & 7);
            wr(PMT_PERIOD_OFS, {24'h0, per});
            wr(PMT_COUNT_OFS, 32'h0);
            wr(PMT_CTRL_OFS, ctrl(1'b1, 2'(s), 4'h0));
            wait_pwm();
            wait_pwm();
            chk("pwm_interval", (per + 1) * 4 * pdiv(2'(s)), t);
            rd(PMT_COUNT_OFS);
            chk("count_in_range", 32'h1, {31'h0, q <= per});
        end
        wr(PMT_MASK_OFS, 32'h1);
        post_tab = '{4'h0, 4'h1, 4'hF, 4'($random(seed))};
        foreach (post_tab[i]) begin
            wr(PMT_CTRL_OFS, ctrl(1'b0, 2'h0, 4'h0));
            wr(PMT_PERIOD_OFS, {24'h0, 8'h08 + 8'($random(seed) & 7)});
            wr(PMT_FLAG_OFS, 32'h1);
            wr(PMT_COUNT_OFS, 32'h0);
            wr(PMT_CTRL_OFS, ctrl(1'b1, 2'h0, post_tab[i]));
            n = 0;
            t = 0;
            while (irq !== 1'b1 && t < 3000) begin
                @(posedge clk_i);
                t++;
                if (pwm === 1'b1)
                    n++;
            end
            chk("post_matches", post_tab[i] + 1, n);
        end
        wr(PMT_CTRL_OFS, ctrl(1'b0, 2'h0, 4'h0));
        wr(PMT_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd(PMT_FLAG_OFS);
        chk("flag_set", 32'h1, q);
        wr(PMT_MASK_OFS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        wr(PMT_FLAG_OFS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        summarize();
    end
endmodule : tb_top
`default_nettype wire
